/* File: logic/clk_src_pkg.sv */
// Shared constants, types and decode helpers for the main clock source control
package clk_src_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;

  // Printed offsets are register indices; byte address is four times each
  localparam logic [19:0] IDX_PIN_MODE = 20'hfffa0;
  localparam logic [19:0] IDX_RUN_CTRL = 20'hfffa1;
  localparam logic [19:0] IDX_CLK_SEL  = 20'hfffa4;

  localparam logic [7:0] RST_PIN_MODE = 8'h00;
  localparam logic [7:0] RST_RUN_CTRL = 8'h80;
  localparam logic [7:0] RST_CLK_SEL  = 8'h00;

  // Field positions
  localparam int PM_EXT_BIT    = 7;
  localparam int PM_OSC_BIT    = 6;
  localparam int PM_GAIN_BIT   = 0;
  localparam int RUN_HS_BIT    = 7;
  localparam int RUN_INT_BIT   = 0;
  localparam int SEL_STAT_BIT  = 5;
  localparam int SEL_SRC_BIT   = 4;

  localparam logic [7:0] PM_WMASK = 8'hc1;

  // Cycles the switch waits, once the target runs, before handing over
  localparam int SWITCH_CYCLES = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PM_PORT_A  = 2'b00,
    PM_CRYSTAL = 2'b01,
    PM_PORT_B  = 2'b10,
    PM_EXTCLK  = 2'b11
  } pin_mode_t;

  typedef enum logic [1:0] {
    REG_NONE = 2'b00,
    REG_PIN  = 2'b01,
    REG_RUN  = 2'b10,
    REG_SEL  = 2'b11
  } reg_sel_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT = 2'b01,
    SW_DONE = 2'b10
  } switch_state_t;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [19:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    if ({addr[ADDR_W-1:2], 2'b00} == reg_addr(IDX_PIN_MODE)) begin
      decode = REG_PIN;
    end else if ({addr[ADDR_W-1:2], 2'b00} == reg_addr(IDX_RUN_CTRL)) begin
      decode = REG_RUN;
    end else if ({addr[ADDR_W-1:2], 2'b00} == reg_addr(IDX_CLK_SEL)) begin
      decode = REG_SEL;
    end else begin
      decode = REG_NONE;
    end
  endfunction

endpackage

/* File: logic/clock_source_switch.sv */
// Sequencer that hands the main clock over between the two sources
`timescale 1ns/1ps
module clock_source_switch #(
  parameter int CYCLES = clk_src_pkg::SWITCH_CYCLES
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Request and source health
  input  wire logic want_hs,
  input  wire logic hs_running,
  input  wire logic int_running,
  // Result
  output logic      active_hs_q,
  output logic      busy_q
);
  import clk_src_pkg::*;

  switch_state_t state_q;
  logic [7:0]    count_q;
  logic          target_ok;

  // A switch towards a stopped source stalls rather than glitching the CPU
  assign target_ok = want_hs ? hs_running : int_running;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= SW_IDLE;
      count_q <= 8'h00;
    end else begin
      case (state_q)
        SW_IDLE: begin
          count_q <= 8'h00;
          if (want_hs != active_hs_q) begin
            state_q <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (want_hs == active_hs_q) begin
            state_q <= SW_IDLE;
          end else if (target_ok) begin
            if (count_q == 8'(CYCLES - 1)) begin
              state_q <= SW_DONE;
            end else begin
              count_q <= count_q + 8'h01;
            end
          end else begin
            count_q <= 8'h00;
          end
        end
        SW_DONE: begin
          state_q <= SW_IDLE;
        end
        default: begin
          state_q <= SW_IDLE;
        end
      endcase
    end
  end

  // Main and peripheral clocks follow this one flop together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_hs_q <= 1'b0;
    end else if (state_q == SW_DONE) begin
      active_hs_q <= want_hs;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q == SW_IDLE) ? (want_hs != active_hs_q)
                                     : (state_q != SW_DONE);
    end
  end

endmodule

/* File: logic/main_clock_source_control.sv */
// Main clock source selection and oscillator run control, AXI4-Lite slave
`timescale 1ns/1ps
module main_clock_source_control #(
  parameter int SWITCH_WAIT = clk_src_pkg::SWITCH_CYCLES
) (
  // Clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // AXI4-Lite write address
  input  wire logic [clk_src_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                     s_axi_awprot,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [clk_src_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [clk_src_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                     s_axi_arprot,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  // AXI4-Lite read data
  output logic [clk_src_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // Stop mode controller
  input  wire logic                           stop_mode_release,
  // Pin function control
  output logic                                crystal_pin_one_osc,
  output logic                                crystal_pin_two_osc,
  output logic                                crystal_pin_two_ext,
  output logic                                high_freq_gain_sel,
  // Oscillator control
  output logic                                crystal_osc_run,
  output logic                                ext_clock_valid,
  output logic                                internal_hs_osc_run,
  output logic                                stab_count_start,
  // Clock tree select, 1 picks the high-speed system clock
  output logic                                main_clock_sel,
  output logic                                periph_clock_sel,
  output logic                                switch_busy
);
  import clk_src_pkg::*;

  // Bus channel state
  logic              awready_q;
  logic              wready_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;

  // Register state
  logic [7:0]        pin_mode_q;
  logic              pin_locked_q;
  logic              hs_halt_q;
  logic              int_halt_q;
  logic              src_sel_q;

  // Derived
  logic              do_write;
  logic              byte0_wr;
  reg_sel_t          wr_sel;
  reg_sel_t          rd_sel;
  pin_mode_t         pin_mode;
  logic              mode_crystal;
  logic              mode_ext;
  logic              mode_port;
  logic              crystal_run_d;
  logic              ext_valid_d;
  logic              active_hs;
  logic              busy;
  logic [7:0]        rd_byte;

  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign byte0_wr = do_write && wstrb_q[0];
  assign wr_sel   = decode(awaddr_q);
  assign rd_sel   = decode(s_axi_araddr);

  // Pin mode decode
  // Codes 00 and 10 both leave the pins to the port logic
  assign pin_mode     = pin_mode_t'({pin_mode_q[PM_EXT_BIT],
                                      pin_mode_q[PM_OSC_BIT]});
  assign mode_crystal = (pin_mode == PM_CRYSTAL);
  assign mode_ext     = (pin_mode == PM_EXTCLK);
  assign mode_port    = !mode_crystal && !mode_ext;

  assign crystal_run_d = mode_crystal && !hs_halt_q;
  assign ext_valid_d   = mode_ext && !hs_halt_q;

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
        awready_q <= 1'b1;
      end
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
        wready_q <= 1'b1;
      end
    end
  end

  // Write response, unmapped addresses answer with an error
  // The response waits one idle cycle after both halves land, which keeps
  // the register update and bvalid on the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Pin mode register: one shot, so a runaway program cannot remap pins
  // A write with byte 0 unstrobed is not the one write the lock counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_mode_q   <= RST_PIN_MODE;
      pin_locked_q <= 1'b0;
    end else if (byte0_wr && wr_sel == REG_PIN && !pin_locked_q) begin
      pin_mode_q   <= wdata_q[7:0] & PM_WMASK;
      pin_locked_q <= 1'b1;
    end
  end

  // Oscillator run control register
  // In port mode the halt bit keeps its value, so a later mode change
  // cannot start an oscillator that was never asked for
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_halt_q  <= RST_RUN_CTRL[RUN_HS_BIT];
      int_halt_q <= RST_RUN_CTRL[RUN_INT_BIT];
    end else if (byte0_wr && wr_sel == REG_RUN) begin
      int_halt_q <= wdata_q[RUN_INT_BIT];
      if (!mode_port) begin
        hs_halt_q <= wdata_q[RUN_HS_BIT];
      end
    end
  end

  // Main clock select register; status bit is not writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_sel_q <= RST_CLK_SEL[SEL_SRC_BIT];
    end else if (byte0_wr && wr_sel == REG_SEL) begin
      src_sel_q <= wdata_q[SEL_SRC_BIT];
    end
  end

  // Switch waits for the target to run before moving the tree select
  // Tree select, peripheral select and status bit share one flop inside
  // the switch, so a status read never runs ahead of the clock tree
  clock_source_switch #(
    .CYCLES      (SWITCH_WAIT)
  ) u_switch (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .want_hs     (src_sel_q),
    .hs_running  (crystal_osc_run || ext_clock_valid),
    .int_running (internal_hs_osc_run),
    .active_hs_q (active_hs),
    .busy_q      (busy)
  );

  assign main_clock_sel   = active_hs;
  assign periph_clock_sel = active_hs;
  assign switch_busy      = busy;

  // Pin function and oscillator outputs
  // Gain only steers the pad amplifier; the choice follows the frequency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_pin_one_osc <= 1'b0;
      crystal_pin_two_osc <= 1'b0;
      crystal_pin_two_ext <= 1'b0;
      high_freq_gain_sel  <= 1'b0;
    end else begin
      crystal_pin_one_osc <= mode_crystal;
      crystal_pin_two_osc <= mode_crystal;
      crystal_pin_two_ext <= mode_ext;
      high_freq_gain_sel  <= pin_mode_q[PM_GAIN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_osc_run     <= 1'b0;
      ext_clock_valid     <= 1'b0;
      internal_hs_osc_run <= 1'b1;
    end else begin
      crystal_osc_run     <= crystal_run_d;
      ext_clock_valid     <= ext_valid_d;
      internal_hs_osc_run <= !int_halt_q;
    end
  end

  // Counter kick on the rising edge of crystal run, or on stop release
  // An external clock needs no build-up time, so it does not kick it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stab_count_start <= 1'b0;
    end else begin
      stab_count_start <= (crystal_run_d && !crystal_osc_run) ||
                          stop_mode_release;
    end
  end

  // Read data mux
  always_comb begin
    rd_byte = 8'h00;
    case (rd_sel)
      REG_PIN: begin
        rd_byte = pin_mode_q;
      end
      REG_RUN: begin
        rd_byte[RUN_HS_BIT]  = hs_halt_q;
        rd_byte[RUN_INT_BIT] = int_halt_q;
      end
      REG_SEL: begin
        rd_byte[SEL_STAT_BIT] = active_hs;
        rd_byte[SEL_SRC_BIT]  = src_sel_q;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Read channel: one read in flight, answered the cycle after acceptance
  // Unmapped reads answer with an error and zero data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= {24'h000000, rd_byte};
        rresp_q   <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule

/* File: test/crystal_source_model.sv */
// Behavioural crystal or external clock source on the clock pins
`timescale 1ns/1ps
module crystal_source_model #(
  parameter real HALF_NS = 41.667
) (
  // Control from the oscillator outputs
  input  wire logic osc_en,
  input  wire logic gain_high,
  // Pin waveform
  output logic      xtal_clk
);
  // A 12 MHz part only swings with the high gain setting
  // Held low while halted so a stopped source never looks like a clock
  initial xtal_clk = 1'b0;
  always begin
    #(HALF_NS);
    xtal_clk = (osc_en && gain_high) ? ~xtal_clk : 1'b0;
  end
endmodule

/* File: test/main_clock_source_checker.sv */
// Port-level assertions for the main clock source control block
`timescale 1ns/1ps
module main_clock_source_checker #(
  parameter int SWITCH_WAIT = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Read channel
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Clock control
  input wire logic stop_mode_release,
  input wire logic crystal_pin_one_osc,
  input wire logic crystal_pin_two_ext,
  input wire logic crystal_osc_run,
  input wire logic ext_clock_valid,
  input wire logic internal_hs_osc_run,
  input wire logic stab_count_start,
  input wire logic main_clock_sel,
  input wire logic periph_clock_sel,
  input wire logic switch_busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles the switch has been pending without a break
  int busy_run_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_run_q <= 0;
    end else begin
      busy_run_q <= switch_busy ? busy_run_q + 1 : 0;
    end
  end

  chk_xtal_mode: assert property (
    crystal_osc_run |-> crystal_pin_one_osc && !crystal_pin_two_ext)
    else $error("crystal runs outside resonator mode");
  chk_ext_mode: assert property (
    ext_clock_valid |-> crystal_pin_two_ext && !crystal_pin_one_osc)
    else $error("external clock valid outside external mode");
  chk_periph_same: assert property (
    periph_clock_sel == main_clock_sel)
    else $error("peripheral clock select differs from main");
  chk_stab_start: assert property (
    $rose(crystal_osc_run) |-> stab_count_start)
    else $error("no stabilization start on crystal start");
  chk_stab_release: assert property (
    stop_mode_release |=> stab_count_start)
    else $error("no stabilization start on stop release");
  chk_sel_settled: assert property (
    $changed(main_clock_sel) |-> $past(switch_busy))
    else $error("main clock changed with no pending switch");
  chk_hs_ready: assert property (
    $rose(main_clock_sel) |-> $past(crystal_osc_run || ext_clock_valid))
    else $error("switched to a stopped system clock");
  chk_int_ready: assert property (
    $fell(main_clock_sel) |-> $past(internal_hs_osc_run))
    else $error("switched to a stopped internal oscillator");
  chk_busy_wait: assert property (
    (switch_busy && !(main_clock_sel ? internal_hs_osc_run
      : (crystal_osc_run || ext_clock_valid))) [*2]
    |=> $stable(main_clock_sel))
    else $error("switch completed toward a stopped source");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_switch_dwell: assert property (
    $changed(main_clock_sel) |-> busy_run_q >= SWITCH_WAIT)
    else $error("main clock changed before the switch wait ran out");
endmodule

bind main_clock_source_control main_clock_source_checker #(
  .SWITCH_WAIT(SWITCH_WAIT)
) chk_u (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .stop_mode_release, .crystal_pin_one_osc, .crystal_pin_two_ext,
  .crystal_osc_run, .ext_clock_valid, .internal_hs_osc_run,
  .stab_count_start, .main_clock_sel, .periph_clock_sel, .switch_busy
);

/* File: test/main_clock_source_control_bench.sv */
// Self-checking bench for the main clock source control block
`timescale 1ns/1ps
module main_clock_source_control_bench;
  import clk_src_pkg::*;
  localparam logic [23:0] A_PIN = 24'h3ffe80;
  localparam logic [23:0] A_RUN = 24'h3ffe84;
  localparam logic [23:0] A_SEL = 24'h3ffe90;
  localparam logic [23:0] A_BAD = 24'h000010;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [23:0] s_axi_awaddr = 24'h0;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_wvalid = 1'b0;
  logic [23:0] s_axi_araddr = 24'h0;
  logic        s_axi_arvalid = 1'b0;
  logic        stop_mode_release = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        crystal_pin_one_osc, crystal_pin_two_osc;
  logic        crystal_pin_two_ext, high_freq_gain_sel;
  logic        crystal_osc_run, ext_clock_valid, internal_hs_osc_run;
  logic        stab_count_start, main_clock_sel, periph_clock_sel;
  logic        switch_busy, xtal_clk;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          xtal_edges = 0;

  always #5 aclk = ~aclk;

  always @(posedge xtal_clk) xtal_edges++;

  // Longer wait than default so a status read can land before the handover
  main_clock_source_control #(.SWITCH_WAIT(8)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
    .stop_mode_release, .crystal_pin_one_osc, .crystal_pin_two_osc,
    .crystal_pin_two_ext, .high_freq_gain_sel, .crystal_osc_run,
    .ext_clock_valid, .internal_hs_osc_run, .stab_count_start,
    .main_clock_sel, .periph_clock_sel, .switch_busy
  );

  crystal_source_model xtal_u (
    .osc_en(crystal_osc_run | ext_clock_valid),
    .gain_high(high_freq_gain_sel | ext_clock_valid),
    .xtal_clk(xtal_clk)
  );

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("MISMATCH at %0t: timeout", $time);
      stop_test();
    end
  end

  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: flag %b want %b", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    idle(10);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [23:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    cmp_val({6'h0, s_axi_bresp}, {6'h0, er});
  endtask

  task automatic rd_chk(input logic [23:0] a, input logic [7:0] ed,
                        input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    cmp_val({6'h0, s_axi_rresp}, {6'h0, er});
    cmp_val(s_axi_rdata[7:0], ed);
  endtask

  initial begin
    int e0;
    e0 = 0;
    do_reset();
    cmp_bit(internal_hs_osc_run, 1'b1);
    cmp_bit(main_clock_sel, 1'b0);
    rd_chk(A_PIN, 8'h00, RESP_OKAY);
    rd_chk(A_RUN, 8'h80, RESP_OKAY);
    rd_chk(A_SEL, 8'h00, RESP_OKAY);
    wr(A_SEL, 8'h20, 4'h1, RESP_OKAY);
    rd_chk(A_SEL, 8'h00, RESP_OKAY);
    wr(A_BAD, 8'h55, 4'h1, RESP_SLVERR);
    rd_chk(A_BAD, 8'h00, RESP_SLVERR);
    $display("Reset and map test done");
    for (int m = 0; m < 4; m++) begin
      do_reset();
      wr(A_PIN, {m[1:0], 6'h00}, 4'h1, RESP_OKAY);
      wr(A_RUN, 8'h00, 4'h1, RESP_OKAY);
      idle(2);
      cmp_bit(crystal_pin_one_osc, m == 1);
      cmp_bit(crystal_pin_two_osc, m == 1);
      cmp_bit(crystal_pin_two_ext, m == 3);
      cmp_bit(crystal_osc_run, m == 1);
      cmp_bit(ext_clock_valid, m == 3);
      rd_chk(A_RUN, m[0] ? 8'h00 : 8'h80, RESP_OKAY);
      wr(A_RUN, 8'h80, 4'h1, RESP_OKAY);
      idle(2);
      cmp_bit(crystal_osc_run | ext_clock_valid, 1'b0);
    end
    $display("Pin mode test done");
    do_reset();
    wr(A_PIN, 8'h41, 4'h0, RESP_OKAY);
    rd_chk(A_PIN, 8'h00, RESP_OKAY);
    wr(A_PIN, 8'h41, 4'h1, RESP_OKAY);
    wr(A_PIN, 8'h80, 4'h1, RESP_OKAY);
    rd_chk(A_PIN, 8'h41, RESP_OKAY);
    cmp_bit(high_freq_gain_sel, 1'b1);
    e0 = xtal_edges;
    wr(A_RUN, 8'h00, 4'h1, RESP_OKAY);
    idle(20);
    cmp_bit(xtal_edges > e0, 1'b1);
    wr(A_SEL, 8'h10, 4'h1, RESP_OKAY);
    rd_chk(A_SEL, 8'h10, RESP_OKAY);
    idle(20);
    rd_chk(A_SEL, 8'h30, RESP_OKAY);
    cmp_bit(main_clock_sel, 1'b1);
    cmp_bit(periph_clock_sel, 1'b1);
    wr(A_RUN, 8'h01, 4'h1, RESP_OKAY);
    idle(2);
    cmp_bit(internal_hs_osc_run, 1'b0);
    wr(A_SEL, 8'h00, 4'h1, RESP_OKAY);
    idle(20);
    cmp_bit(switch_busy, 1'b1);
    cmp_bit(main_clock_sel, 1'b1);
    wr(A_RUN, 8'h00, 4'h1, RESP_OKAY);
    idle(20);
    rd_chk(A_SEL, 8'h00, RESP_OKAY);
    cmp_bit(periph_clock_sel, 1'b0);
    wr(A_RUN, 8'h80, 4'h1, RESP_OKAY);
    idle(2);
    cmp_bit(crystal_osc_run, 1'b0);
    $display("Source switch test done");
    stop_mode_release <= 1'b1;
    @(posedge aclk);
    stop_mode_release <= 1'b0;
    @(posedge aclk);
    cmp_bit(stab_count_start, 1'b1);
    $display("Stop release test done");
    stop_test();
  end
endmodule
